// [logic/lipm_map.svh]
// Register offsets, field positions and reset values for the status-light pin mux
`ifndef LIPM_MAP_SVH
`define LIPM_MAP_SVH

// Word indexes of the registers; the byte address is four times the index
`define LIPM_IDX_WCS      10'h000
`define LIPM_IDX_STRAP    10'h001
`define LIPM_IDX_EVT      10'h002
`define LIPM_IDX_MASK     10'h003

// Wake control and status: light function select fields
`define LIPM_WCS_L1_LSB   0
`define LIPM_WCS_L2_LSB   2
`define LIPM_WCS_L1_RST   2'h0
`define LIPM_WCS_L2_RST   2'h1

// Strap status bits
`define LIPM_STRAP_SEL    0
`define LIPM_STRAP_REG    1

// Event status and mask bits
`define LIPM_EVT_IRQ      0
`define LIPM_EVT_PME      1
`define LIPM_EVT_STRAP    2
`define LIPM_EVT_W        3
`define LIPM_EVT_RST      3'h0
`define LIPM_MASK_RST     3'h0

// Strap defaults before the first capture
`define LIPM_SEL_DEF      1'h1
`define LIPM_REG_DEF      1'h0

// Reference clock and its source oscillator, in MHz
`define LIPM_REF_MHZ      50
`define LIPM_OSC_MHZ      25

`endif

// [logic/lipm_pkg.sv]
// Types shared by the status-light pin mux
package lipm_pkg;

	// Source chosen by a light function select field
	typedef enum logic [1:0] {
		LIPM_SRC_ACT = 2'h0,
		LIPM_SRC_SPD = 2'h1,
		LIPM_SRC_IRQ = 2'h2,
		LIPM_SRC_PME = 2'h3
	} lipm_src_t;

	// Function of the shared interrupt / reference clock pin
	typedef enum logic {
		LIPM_PIN_CLK = 1'h0,
		LIPM_PIN_IRQ = 1'h1
	} lipm_pin_mode_t;

	// Strap capture states
	typedef enum logic [2:0] {
		LIPM_CAP_POR  = 3'h1,
		LIPM_CAP_RUN  = 3'h2,
		LIPM_CAP_HOLD = 3'h4
	} lipm_cap_st_t;

endpackage

// [logic/lipm_sync2.sv]
// Two-flop synchroniser for pin levels
`timescale 1ns/100ps
module lipm_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Levels
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			dout   <= '0;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule

// [logic/lipm_strap_latch.sv]
// Strap capture at power-on and at release of the system reset
`timescale 1ns/100ps
`include "lipm_map.svh"
module lipm_strap_latch (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Synchronised pins
	input  wire logic ext_rst_n_s,
	input  wire logic sel_strap_s,
	input  wire logic reg_strap_s,
	// Held strap values
	output logic      sel_latched,
	output logic      reg_latched,
	output logic      cap_pulse
);
	import lipm_pkg::*;

	lipm_cap_st_t st_r;
	lipm_cap_st_t st_nxt;
	logic         cap_now;

	// Capture only when a reset ends; power-on waits in HOLD, and the synchroniser
	// resets its reset level low, so the first capture sees real strap levels
	assign cap_now = (st_r == LIPM_CAP_HOLD) && ext_rst_n_s;

	always_comb begin
		case (st_r)
			LIPM_CAP_POR:  st_nxt = LIPM_CAP_HOLD;
			LIPM_CAP_RUN:  st_nxt = ext_rst_n_s ? LIPM_CAP_RUN : LIPM_CAP_HOLD;
			LIPM_CAP_HOLD: st_nxt = ext_rst_n_s ? LIPM_CAP_RUN : LIPM_CAP_HOLD;
			default:       st_nxt = LIPM_CAP_POR;
		endcase
	end

	// Async reset loads constants only; the pins are caught by a clocked capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r        <= LIPM_CAP_POR;
			sel_latched <= `LIPM_SEL_DEF;
			reg_latched <= `LIPM_REG_DEF;
			cap_pulse   <= 1'b0;
		end else begin
			st_r      <= st_nxt;
			cap_pulse <= cap_now;
			if (cap_now) begin
				sel_latched <= sel_strap_s;
				reg_latched <= reg_strap_s;
			end
		end
	end

	// Straps are ignored outside a capture
	a_strap_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!cap_now |=> $stable(sel_latched) && $stable(reg_latched))
		else $error("strap value changed outside a capture");
endmodule

// [logic/lipm_pin_mux.sv]
// Status-light, interrupt and reference clock pin mux with its APB registers
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "lipm_map.svh"
module lipm_pin_mux (
	// APB clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Internal event sources, same clock, active high
	input  wire logic                    link_activity,
	input  wire logic                    link_speed,
	input  wire logic                    irq_event,
	input  wire logic                    pme_event,
	// Pins from the board
	input  wire logic                    external_reset_n,
	input  wire logic                    irq_clock_pin_select_strap,
	input  wire logic                    regulator_disable_strap,
	// Pins to the board
	output logic                         status_light_one,
	output logic                         status_light_two,
	output logic                         interrupt_out_n,
	output logic                         ref_clock_out_en,
	output lipm_pkg::lipm_pin_mode_t     shared_pin_mode,
	output logic                         regulator_enable,
	// Block interrupt
	output logic                         irq
);
	import lipm_pkg::*;

	localparam int REF_MUL = `LIPM_REF_MHZ / `LIPM_OSC_MHZ;

	logic [2:0]           pin_s;
	logic                 ext_rst_n_s;
	logic                 sel_latched;
	logic                 reg_latched;
	logic                 cap_pulse;
	lipm_src_t            l1_sel_r;
	lipm_src_t            l2_sel_r;
	logic [`LIPM_EVT_W-1:0] evt_r;
	logic [`LIPM_EVT_W-1:0] mask_r;
	logic [`LIPM_EVT_W-1:0] evt_set;
	logic [`LIPM_EVT_W-1:0] evt_clr;
	logic [`LIPM_EVT_W-1:0] evt_nxt;
	logic [`LIPM_EVT_W-1:0] mask_nxt;
	logic                 irq_d_r;
	logic                 pme_d_r;
	logic                 l1_nxt;
	logic                 l2_nxt;
	lipm_pin_mode_t       mode_nxt;

	// Pins cross two flops before any logic looks at them
	lipm_sync2 #(
		.W (3)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({external_reset_n, irq_clock_pin_select_strap, regulator_disable_strap}),
		.dout    (pin_s)
	);

	assign ext_rst_n_s = pin_s[2];

	lipm_strap_latch u_strap (
		.pclk        (pclk),
		.presetn     (presetn),
		.ext_rst_n_s (ext_rst_n_s),
		.sel_strap_s (pin_s[1]),
		.reg_strap_s (pin_s[0]),
		.sel_latched (sel_latched),
		.reg_latched (reg_latched),
		.cap_pulse   (cap_pulse)
	);

	// Light source selection; interrupt and event are inverted to low-active
	function automatic logic light_src(
		input lipm_src_t s,
		input logic      act,
		input logic      spd,
		input logic      ievt,
		input logic      pevt
	);
		case (s)
			LIPM_SRC_ACT: light_src = act;
			LIPM_SRC_SPD: light_src = spd;
			LIPM_SRC_IRQ: light_src = ~ievt;
			LIPM_SRC_PME: light_src = ~pevt;
			default:      light_src = 1'b0;
		endcase
	endfunction

	// Sources are passed as arguments: an assignment only wakes on its own operands
	assign l1_nxt   = light_src(l1_sel_r, link_activity, link_speed,
	                            irq_event, pme_event);
	assign l2_nxt   = light_src(l2_sel_r, link_activity, link_speed,
	                            irq_event, pme_event);
	assign mode_nxt = sel_latched ? LIPM_PIN_IRQ : LIPM_PIN_CLK;

	// Pin drivers, all registered so no glitch reaches a pad
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_light_one <= 1'b0;
			status_light_two <= 1'b0;
			interrupt_out_n  <= 1'b1;
			ref_clock_out_en <= 1'b0;
			shared_pin_mode  <= LIPM_PIN_IRQ;
			regulator_enable <= 1'b1;
		end else begin
			status_light_one <= l1_nxt;
			status_light_two <= l2_nxt;
			// Held high in clock mode so the pad sees no stray interrupt
			interrupt_out_n  <= (mode_nxt == LIPM_PIN_IRQ) ? ~irq_event : 1'b1;
			ref_clock_out_en <= (mode_nxt == LIPM_PIN_CLK) && (REF_MUL == 2);
			shared_pin_mode  <= mode_nxt;
			regulator_enable <= ~reg_latched;
		end
	end

	// APB decode; one wait-free access phase per transfer
	logic       setup_ph;
	logic       acc_wr;
	logic [9:0] widx;
	logic       hit_wcs;
	logic       hit_strap;
	logic       hit_evt;
	logic       hit_mask;
	logic       hit_any;
	logic [31:0] rd_mux;

	assign setup_ph  = psel && !penable;
	assign acc_wr    = psel && penable && pready && pwrite && !pslverr;
	assign widx      = paddr[11:2];
	assign hit_wcs   = (widx == `LIPM_IDX_WCS);
	assign hit_strap = (widx == `LIPM_IDX_STRAP);
	assign hit_evt   = (widx == `LIPM_IDX_EVT);
	assign hit_mask  = (widx == `LIPM_IDX_MASK);
	assign hit_any   = hit_wcs || hit_strap || hit_evt || hit_mask;
	assign rd_mux    = hit_wcs   ? {28'h0000000, l2_sel_r, l1_sel_r} :
	                   hit_strap ? {30'h00000000, reg_latched, sel_latched} :
	                   hit_evt   ? {29'h00000000, evt_r} :
	                   hit_mask  ? {29'h00000000, mask_r} : 32'h00000000;

	// Bus answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph && !hit_any;
			if (setup_ph && !pwrite) begin
				prdata <= rd_mux;
			end
		end
	end

	// Light select register; a system reset also restores the defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			l1_sel_r <= lipm_src_t'(`LIPM_WCS_L1_RST);
			l2_sel_r <= lipm_src_t'(`LIPM_WCS_L2_RST);
		end else if (!ext_rst_n_s) begin
			l1_sel_r <= lipm_src_t'(`LIPM_WCS_L1_RST);
			l2_sel_r <= lipm_src_t'(`LIPM_WCS_L2_RST);
		end else if (acc_wr && hit_wcs) begin
			l1_sel_r <= lipm_src_t'(pwdata[`LIPM_WCS_L1_LSB +: 2]);
			l2_sel_r <= lipm_src_t'(pwdata[`LIPM_WCS_L2_LSB +: 2]);
		end
	end

	// Sticky events: rising interrupt, rising event, strap capture; set beats clear
	assign evt_set = {cap_pulse, pme_event && !pme_d_r, irq_event && !irq_d_r};
	assign evt_clr = (acc_wr && hit_evt) ? pwdata[`LIPM_EVT_W-1:0] : 3'h0;
	assign evt_nxt = (evt_r & ~evt_clr) | evt_set;
	// New mask feeds irq at once, so irq never lags a mask write
	assign mask_nxt = (acc_wr && hit_mask) ? pwdata[`LIPM_EVT_W-1:0] : mask_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_r   <= `LIPM_EVT_RST;
			mask_r  <= `LIPM_MASK_RST;
			irq_d_r <= 1'b0;
			pme_d_r <= 1'b0;
			irq     <= 1'b0;
		end else begin
			evt_r   <= evt_nxt;
			irq_d_r <= irq_event;
			pme_d_r <= pme_event;
			mask_r  <= mask_nxt;
			irq     <= |(evt_nxt & mask_nxt);
		end
	end

	// Checks on the pin outputs and the block interrupt
	a_light_one_src: assert property (@(posedge pclk) disable iff (!presetn)
		l1_sel_r == LIPM_SRC_ACT |=> status_light_one == $past(link_activity))
		else $error("light one does not follow activity");

	a_light_two_src: assert property (@(posedge pclk) disable iff (!presetn)
		l2_sel_r == LIPM_SRC_SPD |=> status_light_two == $past(link_speed))
		else $error("light two does not follow speed");

	a_irq_shared_pin: assert property (@(posedge pclk) disable iff (!presetn)
		sel_latched && $stable(sel_latched) |=> interrupt_out_n == !$past(irq_event))
		else $error("shared pin does not carry the interrupt");

	a_pme_light_one: assert property (@(posedge pclk) disable iff (!presetn)
		l1_sel_r == LIPM_SRC_PME |=> status_light_one == !$past(pme_event))
		else $error("light one does not carry the event low-active");

	a_irq_light_two: assert property (@(posedge pclk) disable iff (!presetn)
		l2_sel_r == LIPM_SRC_IRQ && irq_event |=> !status_light_two)
		else $error("light two not low while interrupt asserted");

	a_clock_mode_pin: assert property (@(posedge pclk) disable iff (!presetn)
		!sel_latched |=> shared_pin_mode == LIPM_PIN_CLK && interrupt_out_n)
		else $error("shared pin not in clock mode");

	a_ref_clock_en: assert property (@(posedge pclk) disable iff (!presetn)
		ref_clock_out_en |-> shared_pin_mode == LIPM_PIN_CLK && !$past(sel_latched))
		else $error("reference clock enabled outside clock mode");

	a_regulator_en: assert property (@(posedge pclk) disable iff (!presetn)
		cap_pulse |=> regulator_enable == !$past(reg_latched)
			##1 ($stable(regulator_enable) || $past(cap_pulse)))
		else $error("regulator enable does not follow the strap");

	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		(evt_r & mask_r) != 3'h0 |-> irq)
		else $error("interrupt low while an unmasked event is set");

	a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		(evt_r & mask_r) == 3'h0 |-> !irq)
		else $error("interrupt high with no unmasked event");

	// Remaining light sources
	a_light_one_spd: assert property (@(posedge pclk) disable iff (!presetn)
		l1_sel_r == LIPM_SRC_SPD |=> status_light_one == $past(link_speed))
		else $error("light one does not follow speed");

	a_light_one_irq: assert property (@(posedge pclk) disable iff (!presetn)
		l1_sel_r == LIPM_SRC_IRQ |=> status_light_one == !$past(irq_event))
		else $error("light one does not carry the interrupt low-active");

	a_light_two_act: assert property (@(posedge pclk) disable iff (!presetn)
		l2_sel_r == LIPM_SRC_ACT |=> status_light_two == $past(link_activity))
		else $error("light two does not follow activity");

	a_pme_light_two: assert property (@(posedge pclk) disable iff (!presetn)
		l2_sel_r == LIPM_SRC_PME |=> status_light_two == !$past(pme_event))
		else $error("light two does not carry the event low-active");

	// Shared pin and regulator against the held straps; light selects against system reset
	a_irq_mode_pin: assert property (@(posedge pclk) disable iff (!presetn)
		sel_latched |=> shared_pin_mode == LIPM_PIN_IRQ && !ref_clock_out_en)
		else $error("shared pin not in interrupt mode");

	a_regulator_on: assert property (@(posedge pclk) disable iff (!presetn)
		!reg_latched |=> regulator_enable)
		else $error("regulator off with strap low");

	a_regulator_off: assert property (@(posedge pclk) disable iff (!presetn)
		reg_latched |=> !regulator_enable)
		else $error("regulator on with strap high");

	a_ext_rst_selects: assert property (@(posedge pclk) disable iff (!presetn)
		!ext_rst_n_s |=> l1_sel_r == lipm_src_t'(`LIPM_WCS_L1_RST)
			&& l2_sel_r == lipm_src_t'(`LIPM_WCS_L2_RST))
		else $error("light selects not restored by system reset");

	// Event capture; a set in the same cycle as a clear must win
	a_evt_irq_set: assert property (@(posedge pclk) disable iff (!presetn)
		irq_event && !irq_d_r |=> evt_r[`LIPM_EVT_IRQ])
		else $error("interrupt rise not recorded");

	a_evt_pme_set: assert property (@(posedge pclk) disable iff (!presetn)
		pme_event && !pme_d_r |=> evt_r[`LIPM_EVT_PME])
		else $error("power event rise not recorded");

	a_evt_cap_set: assert property (@(posedge pclk) disable iff (!presetn)
		cap_pulse |=> evt_r[`LIPM_EVT_STRAP])
		else $error("strap capture not recorded");

	// Bus answer timing: one access cycle, error only with ready
	a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready)
		else $error("no ready after setup");

	a_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held longer than one cycle");

	a_slverr_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !hit_any |=> pslverr && pready)
		else $error("unmapped access not refused");

	a_slverr_ready: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("error response without ready");
endmodule

// [bench/lipm_board.sv]
// Board model: strap resistors, system reset button and host interrupt input
`timescale 1ns/100ps
module lipm_board (
	// Board controls from the bench
	input  wire logic sel_pull_low,
	input  wire logic reg_pull_high,
	input  wire logic rst_press,
	// Device pins
	input  wire logic interrupt_out_n,
	output logic      external_reset_n,
	output logic      irq_clock_pin_select_strap,
	output logic      regulator_disable_strap,
	// Host side
	output logic      host_irq
);
	// Select strap has a pull-up, so a floating pin reads as interrupt mode
	assign irq_clock_pin_select_strap = !sel_pull_low;
	// Regulator strap has a pull-down, so the regulator stays on by default
	assign regulator_disable_strap = reg_pull_high;
	// Reset button pulls the pulled-up line low
	assign external_reset_n = !rst_press;
	// Host treats a low pin as a pending request
	assign host_irq = !interrupt_out_n;
endmodule

// [bench/tb_led_irq_pin_function_mux.sv]
// Self-checking bench of the status-light pin mux
`timescale 1ns/100ps
`include "lipm_map.svh"
module tb_led_irq_pin_function_mux;
	import lipm_pkg::*;
	localparam logic [11:0] addr_wcs = {`LIPM_IDX_WCS, 2'h0};
	localparam logic [11:0] addr_strap = {`LIPM_IDX_STRAP, 2'h0};
	localparam logic [11:0] addr_evt = {`LIPM_IDX_EVT, 2'h0};
	localparam logic [11:0] addr_mask = {`LIPM_IDX_MASK, 2'h0};
	logic           pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]    paddr;
	logic [31:0]    pwdata, prdata, seed, r;
	logic           act, spd, ievt, pevt, ext_n, sel_s, reg_s, l1, l2, int_n;
	logic           clk_en, reg_en, irq, host_irq, sel_low, reg_high, rst_press;
	lipm_pin_mode_t mode;
	logic [32:0]    exp_q[$];
	int             miscompares, check_count;

	lipm_pin_mux i_lipm_pin_mux (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_activity(act), .link_speed(spd), .irq_event(ievt), .pme_event(pevt),
		.external_reset_n(ext_n), .irq_clock_pin_select_strap(sel_s),
		.regulator_disable_strap(reg_s), .status_light_one(l1), .status_light_two(l2),
		.interrupt_out_n(int_n), .ref_clock_out_en(clk_en), .shared_pin_mode(mode),
		.regulator_enable(reg_en), .irq(irq));
	lipm_board i_lipm_board (
		.sel_pull_low(sel_low), .reg_pull_high(reg_high), .rst_press(rst_press),
		.interrupt_out_n(int_n), .external_reset_n(ext_n),
		.irq_clock_pin_select_strap(sel_s), .regulator_disable_strap(reg_s),
		.host_irq(host_irq));

	// Clock at 25 MHz
	initial begin
		pclk = 1'h0;
		forever #20 pclk = ~pclk;
	end

	task automatic end_sim();
		if (miscompares == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Expected light level for a select code and sources {pme, irq, spd, act}
	function automatic logic pick(input logic [1:0] f, input logic [3:0] v);
		case (lipm_src_t'(f))
			LIPM_SRC_ACT: return v[0];
			LIPM_SRC_SPD: return v[1];
			LIPM_SRC_IRQ: return !v[2];
			default: return !v[3];
		endcase
	endfunction

	// One APB transfer; a read notes {pslverr, prdata} expected for the monitor
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		if (!w) exp_q.push_back(e);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		if (n >= 16) begin
			miscompares++;
			end_sim();
		end
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	// Monitor takes the oldest note when read data is handed over
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'h1 && !pwrite && exp_q.size() > 0) begin
			chk({pslverr, prdata}, exp_q.pop_front());
		end
	end

	// Hang guard
	initial begin
		#800000;
		miscompares++;
		end_sim();
	end

	initial begin
		seed = 32'h0000_4361;
		miscompares = 0;
		check_count = 0;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{act, spd, ievt, pevt, rst_press} = '0;
		sel_low = 1'h1;
		reg_high = 1'h1;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		repeat (6) @(posedge pclk);
		// Power-on capture: clock mode, regulator off
		chk(mode, LIPM_PIN_CLK);
		chk(clk_en, 1'h1);
		chk(int_n, 1'h1);
		chk(reg_en, 1'h0);
		apb(1'h0, addr_wcs, 32'h0, {29'h0, `LIPM_WCS_L2_RST, `LIPM_WCS_L1_RST});
		apb(1'h0, addr_mask, 32'h0, 33'h0);
		apb(1'h0, addr_strap, 32'h0, 33'h2);
		// Strap moves while running are ignored
		sel_low <= 1'h0;
		reg_high <= 1'h0;
		apb(1'h1, addr_wcs, 32'hF, 33'h0);
		repeat (6) @(posedge pclk);
		chk(mode, LIPM_PIN_CLK);
		chk(reg_en, 1'h0);
		apb(1'h0, addr_strap, 32'h0, 33'h2);
		// System reset relatches straps and restores light selects
		rst_press <= 1'h1;
		repeat (4) @(posedge pclk);
		rst_press <= 1'h0;
		repeat (8) @(posedge pclk);
		chk(mode, LIPM_PIN_IRQ);
		chk(clk_en, 1'h0);
		chk(reg_en, 1'h1);
		apb(1'h0, addr_strap, 32'h0, 33'h1);
		apb(1'h0, addr_wcs, 32'h0, 33'h4);
		apb(1'h0, addr_evt, 32'h0, 33'h4);
		// Every select pair against random source levels
		for (int s = 0; s < 16; s++) begin
			apb(1'h1, addr_wcs, {28'h0, s[3:0]}, 33'h0);
			repeat (4) begin
				r = rnd();
				act <= r[0];
				spd <= r[1];
				ievt <= r[2];
				pevt <= r[3];
				repeat (2) @(posedge pclk);
				chk(l1, pick(s[1:0], r[3:0]));
				chk(l2, pick(s[3:2], r[3:0]));
				chk(int_n, !r[2]);
			end
		end
		// Block interrupt: raise, clear, mask
		{act, spd, ievt, pevt} <= 4'h0;
		apb(1'h1, addr_evt, 32'h7, 33'h0);
		apb(1'h1, addr_mask, 32'h1, 33'h0);
		apb(1'h0, addr_evt, 32'h0, 33'h0);
		ievt <= 1'h1;
		repeat (3) @(posedge pclk);
		chk(irq, 1'h1);
		chk(host_irq, 1'h1);
		ievt <= 1'h0;
		apb(1'h1, addr_evt, 32'h1, 33'h0);
		repeat (2) @(posedge pclk);
		chk(irq, 1'h0);
		pevt <= 1'h1;
		repeat (3) @(posedge pclk);
		chk(irq, 1'h0);
		apb(1'h0, addr_evt, 32'h0, 33'h2);
		// Unmapped address and read-only strap status
		apb(1'h0, 12'h010, 32'h0, 33'h1_0000_0000);
		apb(1'h1, addr_strap, 32'h0, 33'h0);
		apb(1'h0, addr_strap, 32'h0, 33'h1);
		repeat (2) @(posedge pclk);
		end_sim();
	end
endmodule
